//--- rtl/ctm_timer.v
// compact 10-bit timer with an AXI4-Lite register slave
`include "ctm_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module ctm_timer #(
  parameter CNT_W = 10                   // counter width
) (
  input  wire        core_clk,           // system clock, 50 MHz
  input  wire        rst,                // synchronous reset, active high
  input  wire        clk_en,             // freezes all state while low
  input  wire        high_clk_tick,      // one-cycle tick of the high clock
  input  wire        time_base_tick,     // one-cycle tick of the time-base clock
  input  wire        external_clock_pin, // external count input
  input  wire [4:0]  s_axi_awaddr,       // write address
  input  wire        s_axi_awvalid,      // write address valid
  output reg         s_axi_awready,      // write address ready
  input  wire [31:0] s_axi_wdata,        // write data
  input  wire [3:0]  s_axi_wstrb,        // write strobes
  input  wire        s_axi_wvalid,       // write data valid
  output reg         s_axi_wready,       // write data ready
  output reg  [1:0]  s_axi_bresp,        // write response
  output reg         s_axi_bvalid,       // write response valid
  input  wire        s_axi_bready,       // write response ready
  input  wire [4:0]  s_axi_araddr,       // read address
  input  wire        s_axi_arvalid,      // read address valid
  output reg         s_axi_arready,      // read address ready
  output reg  [31:0] s_axi_rdata,        // read data
  output reg  [1:0]  s_axi_rresp,        // read response
  output reg         s_axi_rvalid,       // read data valid
  input  wire        s_axi_rready,       // read data ready
  output reg         output_pin_a,       // timer output
  output reg         output_pin_b,       // timer output, same level
  output reg         output_pin_oe,      // pins driven by the timer
  output reg         duty_match_flag,    // one-cycle duty match event
  output reg         period_match_flag   // one-cycle period match event
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [7:0]       ctrl0_reg;
  reg [7:0]       ctrl1_reg;
  reg [CNT_W-1:0] duty_reg;
  reg [7:0]       wbuf_reg;
  reg [7:0]       rbuf_reg;
  reg [CNT_W-1:0] count_reg;
  reg             en_d_reg;
  reg             ext_d_reg;
  reg [1:0]       div4_reg;
  reg [3:0]       h16_reg;
  reg [5:0]       h64_reg;
  reg             out_lvl_reg;
  reg [4:0]       awaddr_reg;
  reg             aw_have_reg;
  reg [31:0]      wdata_reg;
  reg [3:0]       wstrb_reg;
  reg             w_have_reg;

  wire       pause      = ctrl0_reg[`CTM_C0_PAUSE];
  wire [2:0] cksel      = ctrl0_reg[`CTM_C0_CKSEL_HI:`CTM_C0_CKSEL_LO];
  wire       enable     = ctrl0_reg[`CTM_C0_ENABLE];
  wire [2:0] period_fld = ctrl0_reg[`CTM_C0_PER_HI:`CTM_C0_PER_LO];
  wire [1:0] mode       = ctrl1_reg[`CTM_C1_MODE_HI:`CTM_C1_MODE_LO];
  wire [1:0] action     = ctrl1_reg[`CTM_C1_ACT_HI:`CTM_C1_ACT_LO];
  wire       octl       = ctrl1_reg[`CTM_C1_OCTL];
  wire       pol        = ctrl1_reg[`CTM_C1_POL];
  wire       swap       = ctrl1_reg[`CTM_C1_SWAP];
  wire       cclr       = ctrl1_reg[`CTM_C1_CCLR];
  wire       is_pwm     = (mode == `CTM_MODE_PWM);

  // ----------------------------------------
  // timer clock selection
  // ----------------------------------------
  reg tick;
  always @* begin
    case (cksel)
      `CTM_CK_SYS4:     tick = (div4_reg == `CTM_SYS_DIV);
      `CTM_CK_SYS:      tick = 1'b1;
      `CTM_CK_H16:      tick = high_clk_tick && (h16_reg == `CTM_H16_DIV);
      `CTM_CK_H64:      tick = high_clk_tick && (h64_reg == `CTM_H64_DIV);
      `CTM_CK_TBC:      tick = time_base_tick;
      `CTM_CK_EXT_RISE: tick = external_clock_pin && !ext_d_reg;
      `CTM_CK_EXT_FALL: tick = !external_clock_pin && ext_d_reg;
      default:          tick = 1'b0;
    endcase
  end

  // ----------------------------------------
  // comparators and clear
  // ----------------------------------------
  wire       count_run = enable && en_d_reg && !pause && tick;
  wire [CNT_W-1:0] cnt_inc = count_reg + {{(CNT_W-1){1'b0}}, 1'b1};
  wire       ovf       = &count_reg;
  wire [2:0] next_top  = cnt_inc[CNT_W-1:CNT_W-3];
  wire       p_hit     = (period_fld != 3'b000) && (next_top == period_fld)
                         && (cnt_inc[CNT_W-4:0] == {(CNT_W-3){1'b0}});
  wire       a_hit     = (duty_reg != {CNT_W{1'b0}}) && (cnt_inc == duty_reg);
  // pwm period boundary from the period source
  wire       pwm_per_hit = swap ? a_hit : (p_hit || (period_fld == 3'b000 && ovf));
  reg        clr_now;
  always @* begin
    if (is_pwm)
      clr_now = pwm_per_hit;
    else if (cclr)
      clr_now = a_hit || ovf;
    else
      clr_now = p_hit || (period_fld == 3'b000 && ovf);
  end
  wire a_evt = count_run && a_hit;
  wire p_evt = count_run && p_hit && (is_pwm || !cclr);

  // duty in pwm: match of the duty source; at/above period never matches
  wire [CNT_W-1:0] per_val = (period_fld == 3'b000) ? {CNT_W{1'b1}}
                             : {period_fld, {(CNT_W-3){1'b0}}};
  wire pwm_duty_hit = swap ? p_hit : (a_hit && (duty_reg < per_val));

  // ----------------------------------------
  // counter, output and flags
  // ----------------------------------------
  reg pwm_lvl;
  always @* begin
    case (action)
      2'b00:   pwm_lvl = !octl;
      2'b01:   pwm_lvl = octl;
      2'b10:   pwm_lvl = out_lvl_reg ? octl : !octl;
      default: pwm_lvl = !octl;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      count_reg         <= {CNT_W{1'b0}};
      en_d_reg          <= 1'b0;
      ext_d_reg         <= 1'b0;
      div4_reg          <= 2'd0;
      h16_reg           <= 4'd0;
      h64_reg           <= 6'd0;
      out_lvl_reg       <= 1'b0;
      duty_match_flag   <= 1'b0;
      period_match_flag <= 1'b0;
      output_pin_a      <= 1'b0;
      output_pin_b      <= 1'b0;
      output_pin_oe     <= 1'b0;
    end else if (clk_en) begin
      en_d_reg  <= enable;
      ext_d_reg <= external_clock_pin;
      div4_reg  <= div4_reg + 2'd1;
      if (high_clk_tick) begin
        h16_reg <= h16_reg + 4'd1;
        h64_reg <= h64_reg + 6'd1;
      end
      duty_match_flag   <= a_evt;
      period_match_flag <= p_evt;
      if (enable && !en_d_reg) begin
        count_reg <= {CNT_W{1'b0}};
        out_lvl_reg <= is_pwm ? 1'b1 : octl;
      end else if (count_run) begin
        if (clr_now) begin
          count_reg <= {CNT_W{1'b0}};
          if (is_pwm)
            out_lvl_reg <= 1'b1;
        end else begin
          count_reg <= cnt_inc;
        end
        if (is_pwm && pwm_duty_hit && !clr_now)
          out_lvl_reg <= 1'b0;
        else if (!is_pwm && a_hit) begin
          case (action)
            2'b01:   out_lvl_reg <= 1'b0;
            2'b10:   out_lvl_reg <= 1'b1;
            2'b11:   out_lvl_reg <= !out_lvl_reg;
            default: out_lvl_reg <= out_lvl_reg;
          endcase
        end
      end
      output_pin_oe <= (mode != `CTM_MODE_TMR);
      if (mode == `CTM_MODE_TMR) begin
        output_pin_a <= 1'b0;
        output_pin_b <= 1'b0;
      end else begin
        output_pin_a <= (is_pwm ? pwm_lvl : out_lvl_reg) ^ pol;
        output_pin_b <= (is_pwm ? pwm_lvl : out_lvl_reg) ^ pol;
      end
    end
  end

  // ----------------------------------------
  // axi4-lite slave
  // ----------------------------------------
  wire        wr_go  = aw_have_reg && w_have_reg && !s_axi_bvalid;
  wire [4:0]  wa     = awaddr_reg;
  wire [4:0]  ra     = s_axi_araddr;
  wire        rd_go  = s_axi_arvalid && s_axi_arready;
  wire        wr_map = (wa[1:0] == 2'b00) && (wa <= `CTM_OFF_DUTY_HI);
  wire        rd_map = (ra[1:0] == 2'b00) && (ra <= `CTM_OFF_DUTY_HI);
  reg  [7:0]  rd_byte;
  always @* begin
    case (ra)
      {1'b0, `CTM_OFF_CTRL0}:  rd_byte = ctrl0_reg;
      {1'b0, `CTM_OFF_CTRL1}:  rd_byte = ctrl1_reg;
      {1'b0, `CTM_OFF_CNT_LO}: rd_byte = rbuf_reg;
      {1'b0, `CTM_OFF_CNT_HI}: rd_byte = {6'd0, count_reg[9:8]};
      `CTM_OFF_DUTY_LO:        rd_byte = rbuf_reg;
      `CTM_OFF_DUTY_HI:        rd_byte = {6'd0, duty_reg[9:8]};
      default:                 rd_byte = 8'h00;
    endcase
  end

  always @(posedge core_clk) begin
    if (rst) begin
      ctrl0_reg     <= `CTM_RST_CTRL0;
      ctrl1_reg     <= `CTM_RST_CTRL1;
      duty_reg      <= {CNT_W{1'b0}};
      wbuf_reg      <= 8'h00;
      rbuf_reg      <= 8'h00;
      awaddr_reg    <= 5'd0;
      aw_have_reg   <= 1'b0;
      wdata_reg     <= 32'h0000_0000;
      wstrb_reg     <= 4'h0;
      w_have_reg    <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `CTM_AXI_OKAY;
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rresp   <= `CTM_AXI_OKAY;
      s_axi_rdata   <= 32'h0000_0000;
    end else if (clk_en) begin
      s_axi_awready <= !aw_have_reg && !s_axi_awready && !s_axi_bvalid;
      s_axi_wready  <= !w_have_reg && !s_axi_wready && !s_axi_bvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_reg  <= s_axi_awaddr;
        aw_have_reg <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_reg  <= s_axi_wdata;
        wstrb_reg  <= s_axi_wstrb;
        w_have_reg <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_have_reg  <= 1'b0;
        w_have_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? `CTM_AXI_OKAY : `CTM_AXI_SLVERR;
        if (wstrb_reg[0]) begin
          case (wa)
            {1'b0, `CTM_OFF_CTRL0}: ctrl0_reg <= wdata_reg[7:0];
            {1'b0, `CTM_OFF_CTRL1}: ctrl1_reg <= wdata_reg[7:0];
            `CTM_OFF_DUTY_LO:       wbuf_reg  <= wdata_reg[7:0];
            `CTM_OFF_DUTY_HI:       duty_reg  <= {wdata_reg[1:0], wbuf_reg};
            default:                wbuf_reg  <= wbuf_reg;
          endcase
        end
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid;
      if (rd_go) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid  <= 1'b1;
        s_axi_rdata   <= {24'h000000, rd_byte};
        s_axi_rresp   <= rd_map ? `CTM_AXI_OKAY : `CTM_AXI_SLVERR;
        if (ra == {1'b0, `CTM_OFF_CNT_HI})
          rbuf_reg <= count_reg[7:0];
        else if (ra == `CTM_OFF_DUTY_HI)
          rbuf_reg <= duty_reg[7:0];
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

`default_nettype wire

//--- shared/ctm_consts.vh
// constants for the compact 10-bit timer: offsets, fields, reset values, codes
`ifndef CTM_CONSTS_VH
`define CTM_CONSTS_VH

// ----------------------------------------
// register byte addresses
// ----------------------------------------
`define CTM_OFF_CTRL0      4'h0
`define CTM_OFF_CTRL1      4'h4
`define CTM_OFF_CNT_LO     4'h8
`define CTM_OFF_CNT_HI     4'hc
`define CTM_OFF_DUTY_LO    5'h10
`define CTM_OFF_DUTY_HI    5'h14

// ----------------------------------------
// reset values
// ----------------------------------------
`define CTM_RST_CTRL0      8'h00
`define CTM_RST_CTRL1      8'h00

// ----------------------------------------
// control 0 fields
// ----------------------------------------
`define CTM_C0_PAUSE       7
`define CTM_C0_CKSEL_HI    6
`define CTM_C0_CKSEL_LO    4
`define CTM_C0_ENABLE      3
`define CTM_C0_PER_HI      2
`define CTM_C0_PER_LO      0

// ----------------------------------------
// control 1 fields
// ----------------------------------------
`define CTM_C1_MODE_HI     7
`define CTM_C1_MODE_LO     6
`define CTM_C1_ACT_HI      5
`define CTM_C1_ACT_LO      4
`define CTM_C1_OCTL        3
`define CTM_C1_POL         2
`define CTM_C1_SWAP        1
`define CTM_C1_CCLR        0

// ----------------------------------------
// codes
// ----------------------------------------
`define CTM_MODE_CMP       2'b00
`define CTM_MODE_PWM       2'b10
`define CTM_MODE_TMR       2'b11
`define CTM_CK_SYS4        3'b000
`define CTM_CK_SYS         3'b001
`define CTM_CK_H16         3'b010
`define CTM_CK_H64         3'b011
`define CTM_CK_TBC         3'b100
`define CTM_CK_NONE        3'b101
`define CTM_CK_EXT_RISE    3'b110
`define CTM_CK_EXT_FALL    3'b111
`define CTM_SYS_DIV        2'd3
`define CTM_H16_DIV        4'd15
`define CTM_H64_DIV        6'd63
`define CTM_AXI_OKAY       2'b00
`define CTM_AXI_SLVERR     2'b10

`endif

//--- tb/ctm_timer_asserts.sv
// port-level checks for the compact timer
`include "ctm_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module ctm_timer_asserts (
  input wire logic        core_clk,          // clock
  input wire logic        rst,               // reset
  input wire logic [4:0]  s_axi_awaddr,      // aw address
  input wire logic        s_axi_awvalid,     // aw valid
  input wire logic        s_axi_awready,     // aw ready
  input wire logic [31:0] s_axi_wdata,       // w data
  input wire logic [3:0]  s_axi_wstrb,       // w strobes
  input wire logic        s_axi_wvalid,      // w valid
  input wire logic        s_axi_wready,      // w ready
  input wire logic [1:0]  s_axi_bresp,       // b response
  input wire logic        s_axi_bvalid,      // b valid
  input wire logic        s_axi_bready,      // b ready
  input wire logic [31:0] s_axi_rdata,       // r data
  input wire logic        s_axi_rvalid,      // r valid
  input wire logic        s_axi_rready,      // r ready
  input wire logic        output_pin_a,      // pin a
  input wire logic        output_pin_b,      // pin b
  input wire logic        output_pin_oe,     // pin enable
  input wire logic        period_match_flag  // period event
);
  // ----------------------------------------
  // control registers seen from the bus
  // ----------------------------------------
  wire        hs = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  wire        wr = hs && s_axi_wstrb[0];
  logic [7:0] c0_reg;
  logic [7:0] c1_reg;
  logic [1:0] age_reg;
  wire  [1:0] mode = c1_reg[7:6];
  wire        lvl  = c1_reg[3] ^ c1_reg[2];
  wire        calm = age_reg == 2'd3;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      c0_reg <= 8'h00;
      c1_reg <= 8'h00;
      age_reg <= 2'h0;
    end else if (wr) begin
      age_reg <= 2'h0;
      if (s_axi_awaddr == `CTM_OFF_CTRL0) c0_reg <= s_axi_wdata[7:0];
      if (s_axi_awaddr == `CTM_OFF_CTRL1) c1_reg <= s_axi_wdata[7:0];
    end else if (!calm) begin
      age_reg <= age_reg + 2'd1;
    end
  end
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_pins_same: assert property (output_pin_a == output_pin_b)
    else $error("output pins differ");
  a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("read data upper bits set");
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_no_period_flag: assert property (mode != `CTM_MODE_PWM && c1_reg[0] && calm |-> !period_match_flag)
    else $error("period flag with duty clear");
  a_timer_undriven: assert property (mode == `CTM_MODE_TMR && calm |-> !output_pin_oe)
    else $error("pins driven in timer mode");
  a_pins_driven: assert property ((mode == `CTM_MODE_CMP || mode == `CTM_MODE_PWM) && calm |-> output_pin_oe)
    else $error("pins not driven");
  a_pwm_forced: assert property (mode == `CTM_MODE_PWM && c0_reg[3] && !c1_reg[5] && calm
    |-> output_pin_a == (c1_reg[4] ? lvl : !lvl))
    else $error("forced pwm level wrong");
  a_cmp_initial: assert property (wr && s_axi_awaddr == `CTM_OFF_CTRL0 && s_axi_wdata[3] && !c0_reg[3]
    && s_axi_wdata[6:4] == `CTM_CK_NONE && mode == `CTM_MODE_CMP |-> ##[1:4] output_pin_a == lvl)
    else $error("initial level wrong");
  c_write: cover property (wr);
  c_period: cover property (period_match_flag);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind ctm_timer ctm_timer_asserts u_chk (.core_clk(core_clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
  .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .output_pin_a(output_pin_a), .output_pin_b(output_pin_b), .output_pin_oe(output_pin_oe),
  .period_match_flag(period_match_flag));
`default_nettype wire

//--- tb/ctm_timer_tb.sv
// register-level testbench for the compact timer
`include "ctm_consts.vh"
`timescale 1ns/1ps
`default_nettype none
module ctm_timer_tb;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        hct = 1'b0, tbt = 1'b0, ext = 1'b0;
  logic [4:0]  awa = 5'h00, ara = 5'h00;
  logic [31:0] wd = 32'h0;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
  wire         awr, wrd, bv, arr, rv, pa, pb, poe, daf, paf;
  wire  [1:0]  br, rr;
  wire  [31:0] rd;
  int          err_total = 0, comparisons = 0, cyc = 0;
  int          paf_n = 0, daf_n = 0;

  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    hct <= cyc[0];
    tbt <= cyc[2:0] == 3'd0;
    ext <= cyc[2];
  end
  // event pulse tallies
  always @(posedge clk) begin
    if (paf === 1'b1) paf_n <= paf_n + 1;
    if (daf === 1'b1) daf_n <= daf_n + 1;
  end

  ctm_timer u_dut (.core_clk(clk), .rst(rst), .clk_en(1'b1), .high_clk_tick(hct),
    .time_base_tick(tbt), .external_clock_pin(ext), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
    .s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hf), .s_axi_wvalid(wv),
    .s_axi_wready(wrd), .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_rdata(rd),
    .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry), .output_pin_a(pa),
    .output_pin_b(pb), .output_pin_oe(poe), .duty_match_flag(daf), .period_match_flag(paf));

  // ----------------------------------------
  // bus and check tasks
  // ----------------------------------------
  task automatic err(input string m);
    err_total++;
    $display("Error at %0t: %s", $time, m);
  endtask
  task automatic chk(input logic [9:0] g, input logic [9:0] e);
    comparisons++;
    if (g !== e) err("value mismatch");
  endtask
  task automatic bus_wr(input logic [4:0] a, input logic [7:0] d);
    int n = 0;
    @(posedge clk);
    awa <= a;
    wd <= {24'h0, d};
    awv <= 1'b1;
    wv <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (awr) awv <= 1'b0;
      if (wrd) wv <= 1'b0;
    end while (bv !== 1'b1 && n < 50);
    bry <= 1'b0;
    if (bv !== 1'b1) err("write stalled");
  endtask
  task automatic bus_rd(input logic [4:0] a, output logic [7:0] d, output logic [1:0] r);
    int n = 0;
    @(posedge clk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (arr) arv <= 1'b0;
    end while (rv !== 1'b1 && n < 50);
    rry <= 1'b0;
    d = rd[7:0];
    r = rr;
    if (rv !== 1'b1) err("read stalled");
  endtask
  task automatic rd_cnt(output logic [9:0] v);
    logic [7:0] h, l;
    logic [1:0] r;
    bus_rd(`CTM_OFF_CNT_HI, h, r);
    bus_rd(`CTM_OFF_CNT_LO, l, r);
    chk(10'(h[7:2]), 10'h000);
    v = {h[1:0], l};
  endtask
  task automatic test_done;
    if (err_total == 0 && comparisons > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    #1_000_000;
    err("watchdog expired");
    test_done;
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    logic [7:0] v;
    logic [1:0] r;
    logic [9:0] c1, c2;
    int         i, n, p0, d0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 7; i++) begin
      bus_rd(5'(i * 4), v, r);
      chk(10'(v), 10'h000);
      chk(10'(r), (i == 6) ? 10'(`CTM_AXI_SLVERR) : 10'(`CTM_AXI_OKAY));
    end
    bus_wr(`CTM_OFF_CTRL1, 8'hda);
    bus_rd(`CTM_OFF_CTRL1, v, r);
    chk(10'(v), 10'h0da);
    bus_wr(`CTM_OFF_CTRL0, 8'h57);
    bus_wr(`CTM_OFF_CNT_LO, 8'h55);
    rd_cnt(c1);
    chk(c1, 10'h000);
    for (i = 0; i < 4; i++) begin
      bus_wr(`CTM_OFF_CTRL0, 8'h50);
      bus_wr(`CTM_OFF_CTRL1, 8'({i[1], i[0], 2'b00}));
      bus_wr(`CTM_OFF_CTRL0, 8'h58);
      repeat (5) @(posedge clk);
      chk(10'(pa), 10'(i[1] ^ i[0]));
      bus_wr(`CTM_OFF_CTRL0, 8'h00);
      bus_wr(`CTM_OFF_CTRL1, {3'b100, i[0], 1'b1, i[1], 2'b00});
      bus_wr(`CTM_OFF_CTRL0, 8'h19);
      repeat (10) @(posedge clk);
      chk(10'(pa), 10'(i[0] ^ i[1]));
    end
    bus_wr(`CTM_OFF_CTRL0, 8'h50);
    bus_wr(`CTM_OFF_CTRL1, 8'hc0);
    for (i = 0; i < 8; i++) begin
      bus_wr(`CTM_OFF_CTRL0, {1'b0, 3'(i), 4'h8});
      repeat (300) @(posedge clk);
      bus_wr(`CTM_OFF_CTRL0, {1'b0, 3'(i), 4'h0});
      rd_cnt(c1);
      repeat (20) @(posedge clk);
      rd_cnt(c2);
      chk(c2, c1);
      chk(10'(c1 != 10'h0), 10'(i != 5));
    end
    chk(10'(poe), 10'h000);
    bus_wr(`CTM_OFF_CTRL0, 8'h18);
    repeat (50) @(posedge clk);
    bus_wr(`CTM_OFF_CTRL0, 8'h98);
    rd_cnt(c1);
    repeat (20) @(posedge clk);
    rd_cnt(c2);
    chk(c2, c1);
    bus_wr(`CTM_OFF_CTRL0, 8'h18);
    repeat (20) @(posedge clk);
    rd_cnt(c2);
    chk(10'(c2 > c1), 10'h001);
    bus_wr(`CTM_OFF_CTRL0, 8'h50);
    bus_wr(`CTM_OFF_DUTY_LO, 8'h20);
    bus_wr(`CTM_OFF_DUTY_HI, 8'h00);
    bus_wr(`CTM_OFF_CTRL0, 8'h19);
    for (i = 0; i < 16; i++) begin
      if (i == 8) begin
        chk(10'(paf_n > 0), 10'h001);
        bus_wr(`CTM_OFF_CTRL0, 8'h50);
        bus_wr(`CTM_OFF_CTRL1, 8'hc1);
        bus_wr(`CTM_OFF_CTRL0, 8'h19);
        p0 = paf_n;
        d0 = daf_n;
      end
      repeat (37) @(posedge clk);
      rd_cnt(c1);
      if (i < 8) chk(10'(c1 < 10'd128), 10'h001);
      else chk(10'(c1 <= 10'h020), 10'h001);
    end
    chk(10'(paf_n == p0), 10'h001);
    chk(10'(daf_n > d0), 10'h001);
    bus_wr(`CTM_OFF_DUTY_LO, 8'hab);
    bus_rd(`CTM_OFF_DUTY_HI, v, r);
    bus_rd(`CTM_OFF_DUTY_LO, v, r);
    chk(10'(v), 10'h020);
    bus_wr(`CTM_OFF_DUTY_HI, 8'hff);
    bus_rd(`CTM_OFF_DUTY_HI, v, r);
    chk(10'(v), 10'h003);
    bus_rd(`CTM_OFF_DUTY_LO, v, r);
    chk(10'(v), 10'h0ab);
    for (i = 0; i < 3; i++) begin
      c1 = (i == 0) ? 10'h3ab : (i == 1) ? 10'h020 : 10'h100;
      bus_wr(`CTM_OFF_CTRL0, 8'h00);
      bus_wr(`CTM_OFF_DUTY_LO, c1[7:0]);
      bus_wr(`CTM_OFF_DUTY_HI, 8'(c1[9:8]));
      bus_wr(`CTM_OFF_CTRL1, (i == 2) ? 8'haa : 8'ha8);
      bus_wr(`CTM_OFF_CTRL0, 8'h19);
      repeat (20) @(posedge clk);
      n = 0;
      repeat (512) begin
        @(posedge clk);
        n += int'(pa);
      end
      c2 = (i == 0) ? 10'd512 : 10'(i * 128);
      if (i == 0) chk(10'(n), c2);
      else chk(10'(n >= c2 - 8 && n <= c2 + 8), 10'h001);
    end
    test_done;
  end
endmodule
`default_nettype wire
